// [rtl/sac_pkg.sv]
// Shared constants and types for the step attenuator control block
package sac_pkg;

    // Attenuation code and serial word widths
    localparam int ATTEN_W = 5;
    localparam int SHIFT_W = 6;
    localparam int STOP_IDX = 0;
    localparam int CODE_LSB = 1;

    // Strap-selected power-up codes in parallel mode
    localparam logic [ATTEN_W-1:0] ATTEN_REF_LOSS = 5'h00;
    localparam logic [ATTEN_W-1:0] ATTEN_STRAP_B_ONLY = 5'h08;
    localparam logic [ATTEN_W-1:0] ATTEN_STRAP_A_ONLY = 5'h10;
    localparam logic [ATTEN_W-1:0] ATTEN_STRAP_BOTH = 5'h1f;
    localparam logic STOP_BIT_PRELOAD = 1'b0;

    // Pin synchroniser lanes
    localparam int SYNC_W = 11;
    localparam int SYN_CODE_LSB = 0;
    localparam int SYN_MODE = 5;
    localparam int SYN_STROBE = 6;
    localparam int SYN_SCLK = 7;
    localparam int SYN_SDATA = 8;
    localparam int SYN_STRAP_A = 9;
    localparam int SYN_STRAP_B = 10;

    // AXI4-Lite register map
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] REG_SHIFT = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status fields
    localparam int STAT_ATTEN_LSB = 0;
    localparam int STAT_MODE_BIT = 8;
    localparam int STAT_STROBE_BIT = 9;
    localparam int STAT_STOP_BIT = 10;
    localparam int STAT_RUN_BIT = 11;

    // Control fields
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_FORCE_BIT = 8;
    localparam logic [ATTEN_W-1:0] CTRL_CODE_RST = 5'h00;
    localparam int CTRL_CODE_LANE = 0;
    localparam int CTRL_FORCE_LANE = 1;

    typedef enum logic [1:0] {
        SAC_PH_FILL1,
        SAC_PH_FILL2,
        SAC_PH_STRAP,
        SAC_PH_RUN
    } sac_phase_e;

endpackage

// [rtl/sac_sync.sv]
// Two-stage synchroniser for the asynchronous control pins
`timescale 1ns/10ps
module sac_sync
    import sac_pkg::*;
(
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic [SYNC_W-1:0] i_async, // Raw pin levels
    output logic [SYNC_W-1:0] o_sync // Synchronised levels
);

    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_lane
            // First stage feeds only the second stage
            always_ff @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end
                else
                begin
                    meta_reg[gi] <= i_async[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    assign o_sync = sync_reg;

endmodule // sac_sync

// [rtl/sac_top.sv]
// Step attenuator control: parallel/serial pin interface plus AXI4-Lite status
`timescale 1ns/10ps
module sac_top
    import sac_pkg::*;
(
    input wire logic i_core_clk, // Core clock, 100 MHz
    input wire logic i_rst_n, // Async reset, active low (power-up)
    input wire logic i_mode_serial, // Interface select strap, high = serial
    input wire logic i_latch_strobe, // Latch strobe pin
    input wire logic i_serial_clk, // Serial clock pin
    input wire logic i_serial_data, // Serial data pin
    input wire logic i_atten_bit_16db, // Parallel control, 16 dB
    input wire logic i_atten_bit_8db, // Parallel control, 8 dB
    input wire logic i_atten_bit_4db, // Parallel control, 4 dB
    input wire logic i_atten_bit_2db, // Parallel control, 2 dB
    input wire logic i_atten_bit_1db, // Parallel control, 1 dB
    input wire logic i_powerup_strap_a, // Power-up strap, 16 dB
    input wire logic i_powerup_strap_b, // Power-up strap, 8 dB
    output logic [ATTEN_W-1:0] o_atten, // Applied attenuation code, dB
    output logic o_serial_stop_bit, // Latched stop bit, high is illegal
    input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr, // Write address
    input wire logic i_s_axi_awvalid, // Write address valid
    output logic o_s_axi_awready, // Write address ready
    input wire logic [AXI_DATA_W-1:0] i_s_axi_wdata, // Write data
    input wire logic [AXI_STRB_W-1:0] i_s_axi_wstrb, // Write strobes
    input wire logic i_s_axi_wvalid, // Write data valid
    output logic o_s_axi_wready, // Write data ready
    output logic [1:0] o_s_axi_bresp, // Write response
    output logic o_s_axi_bvalid, // Write response valid
    input wire logic i_s_axi_bready, // Write response ready
    input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr, // Read address
    input wire logic i_s_axi_arvalid, // Read address valid
    output logic o_s_axi_arready, // Read address ready
    output logic [AXI_DATA_W-1:0] o_s_axi_rdata, // Read data
    output logic [1:0] o_s_axi_rresp, // Read response
    output logic o_s_axi_rvalid, // Read data valid
    input wire logic i_s_axi_rready // Read data ready
);

    typedef struct packed {
        sac_phase_e phase;
        logic sclk_prev;
        logic [SHIFT_W-1:0] shift;
        logic [SHIFT_W-1:0] hold;
        logic [ATTEN_W-1:0] atten;
        logic stop;
        logic force_en;
        logic [ATTEN_W-1:0] force_code;
        logic aw_have;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic w_have;
        logic [AXI_DATA_W-1:0] wdata;
        logic [AXI_STRB_W-1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [AXI_DATA_W-1:0] rdata;
    } sac_state_s;

    localparam sac_state_s SAC_STATE_RST = '0;

    sac_state_s state_reg;
    sac_state_s state_next;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins;
    logic [ATTEN_W-1:0] par_code;
    logic mode_serial;
    logic strobe;
    logic sclk_rise;
    logic [SHIFT_W-1:0] par_word;

    // Pins cross into the core domain before anything reads them
    assign pins_raw = {
        i_powerup_strap_b,
        i_powerup_strap_a,
        i_serial_data,
        i_serial_clk,
        i_latch_strobe,
        i_mode_serial,
        i_atten_bit_16db,
        i_atten_bit_8db,
        i_atten_bit_4db,
        i_atten_bit_2db,
        i_atten_bit_1db
    };

    sac_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    assign par_code = pins[SYN_CODE_LSB +: ATTEN_W];
    assign mode_serial = pins[SYN_MODE];
    assign strobe = pins[SYN_STROBE];
    assign par_word = {par_code, STOP_BIT_PRELOAD};

    always_comb
    begin
        state_next = state_reg;
        // Edge found on synchronised levels; serial clock is slow enough
        sclk_rise = pins[SYN_SCLK] & ~state_reg.sclk_prev;
        state_next.sclk_prev = pins[SYN_SCLK];

        case (state_reg.phase)
            SAC_PH_FILL1:
            begin
                state_next.phase = SAC_PH_FILL2;
            end
            SAC_PH_FILL2:
            begin
                // Synchroniser holds true pin levels only from here on
                state_next.phase = SAC_PH_STRAP;
            end
            SAC_PH_STRAP:
            begin
                if (mode_serial)
                begin
                    state_next.shift = par_word;
                    state_next.hold = par_word;
                end
                else if (strobe)
                begin
                    state_next.hold = par_word;
                end
                else
                begin
                    case ({pins[SYN_STRAP_A], pins[SYN_STRAP_B]})
                        2'h0: state_next.hold = {ATTEN_REF_LOSS, STOP_BIT_PRELOAD};
                        2'h1: state_next.hold = {ATTEN_STRAP_B_ONLY, STOP_BIT_PRELOAD};
                        2'h2: state_next.hold = {ATTEN_STRAP_A_ONLY, STOP_BIT_PRELOAD};
                        default: state_next.hold = {ATTEN_STRAP_BOTH, STOP_BIT_PRELOAD};
                    endcase
                end
                state_next.phase = SAC_PH_RUN;
            end
            default:
            begin
                // Shift runs in every mode and at any strobe level
                if (sclk_rise)
                begin
                    state_next.shift = {state_reg.shift[SHIFT_W-2:0], pins[SYN_SDATA]};
                end
                if (strobe)
                begin
                    if (mode_serial)
                    begin
                        state_next.hold = state_next.shift;
                    end
                    else
                    begin
                        // Transparent while high covers direct and latched use
                        state_next.hold = par_word;
                    end
                end
                // Strobe low keeps the last word: the freeze of a falling strobe
            end
        endcase

        // Code bits map one to one onto weights, so every code is legal
        if (state_reg.force_en)
        begin
            state_next.atten = state_reg.force_code;
        end
        else
        begin
            state_next.atten = state_next.hold[CODE_LSB +: ATTEN_W];
        end
        state_next.stop = state_next.hold[STOP_IDX];

        // AXI4-Lite write channel: address and data in either order
        if (state_reg.bvalid && i_s_axi_bready)
        begin
            state_next.bvalid = 1'b0;
        end
        if (state_reg.awready && i_s_axi_awvalid)
        begin
            state_next.aw_have = 1'b1;
            state_next.awaddr = i_s_axi_awaddr;
        end
        if (state_reg.wready && i_s_axi_wvalid)
        begin
            state_next.w_have = 1'b1;
            state_next.wdata = i_s_axi_wdata;
            state_next.wstrb = i_s_axi_wstrb;
        end
        if (state_next.aw_have && state_next.w_have && !state_next.bvalid)
        begin
            state_next.aw_have = 1'b0;
            state_next.w_have = 1'b0;
            state_next.bvalid = 1'b1;
            if (state_next.awaddr == REG_CTRL)
            begin
                state_next.bresp = RESP_OKAY;
                if (state_next.wstrb[CTRL_CODE_LANE])
                begin
                    state_next.force_code = state_next.wdata[CTRL_CODE_LSB +: ATTEN_W];
                end
                if (state_next.wstrb[CTRL_FORCE_LANE])
                begin
                    state_next.force_en = state_next.wdata[CTRL_FORCE_BIT];
                end
            end
            else if (state_next.awaddr == REG_STATUS || state_next.awaddr == REG_SHIFT)
            begin
                // Read-only words: write is dropped but acknowledged
                state_next.bresp = RESP_OKAY;
            end
            else
            begin
                state_next.bresp = RESP_SLVERR;
            end
        end
        // Ready held low while a word or a response is pending
        state_next.awready = !state_next.aw_have && !state_next.bvalid;
        state_next.wready = !state_next.w_have && !state_next.bvalid;

        // AXI4-Lite read channel
        if (state_reg.rvalid && i_s_axi_rready)
        begin
            state_next.rvalid = 1'b0;
        end
        if (state_reg.arready && i_s_axi_arvalid)
        begin
            state_next.rvalid = 1'b1;
            state_next.rdata = '0;
            state_next.rresp = RESP_OKAY;
            if (i_s_axi_araddr == REG_STATUS)
            begin
                state_next.rdata[STAT_ATTEN_LSB +: ATTEN_W] = state_reg.atten;
                state_next.rdata[STAT_MODE_BIT] = mode_serial;
                state_next.rdata[STAT_STROBE_BIT] = strobe;
                state_next.rdata[STAT_STOP_BIT] = state_reg.stop;
                state_next.rdata[STAT_RUN_BIT] = (state_reg.phase == SAC_PH_RUN);
            end
            else if (i_s_axi_araddr == REG_CTRL)
            begin
                state_next.rdata[CTRL_CODE_LSB +: ATTEN_W] = state_reg.force_code;
                state_next.rdata[CTRL_FORCE_BIT] = state_reg.force_en;
            end
            else if (i_s_axi_araddr == REG_SHIFT)
            begin
                state_next.rdata[SHIFT_W-1:0] = state_reg.shift;
            end
            else
            begin
                state_next.rresp = RESP_SLVERR;
            end
        end
        state_next.arready = !state_next.rvalid;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= SAC_STATE_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_atten = state_reg.atten;
    assign o_serial_stop_bit = state_reg.stop;
    assign o_s_axi_awready = state_reg.awready;
    assign o_s_axi_wready = state_reg.wready;
    assign o_s_axi_bresp = state_reg.bresp;
    assign o_s_axi_bvalid = state_reg.bvalid;
    assign o_s_axi_arready = state_reg.arready;
    assign o_s_axi_rdata = state_reg.rdata;
    assign o_s_axi_rresp = state_reg.rresp;
    assign o_s_axi_rvalid = state_reg.rvalid;

endmodule // sac_top

// [test/sac_top_properties.sv]
// Concurrent checks on the attenuator control block ports
`timescale 1ns/10ps
module sac_top_properties
    import sac_pkg::*;
(
    input wire logic i_core_clk, // Clock
    input wire logic i_rst_n, // Reset
    input wire logic i_mode_serial, // Mode pin
    input wire logic i_latch_strobe, // Strobe pin
    input wire logic i_atten_bit_16db, // Line
    input wire logic i_atten_bit_8db, // Line
    input wire logic i_atten_bit_4db, // Line
    input wire logic i_atten_bit_2db, // Line
    input wire logic i_atten_bit_1db, // Line
    input wire logic [ATTEN_W-1:0] o_atten, // Code
    input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr, // AW
    input wire logic i_s_axi_awvalid, // AW
    input wire logic o_s_axi_awready, // AW
    input wire logic [AXI_DATA_W-1:0] i_s_axi_wdata, // W
    input wire logic [AXI_STRB_W-1:0] i_s_axi_wstrb, // W
    input wire logic i_s_axi_wvalid, // W
    input wire logic o_s_axi_wready, // W
    input wire logic o_s_axi_bvalid, // B
    input wire logic i_s_axi_bready, // B
    input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr, // AR
    input wire logic i_s_axi_arvalid, // AR
    input wire logic o_s_axi_arready, // AR
    input wire logic [AXI_DATA_W-1:0] o_s_axi_rdata, // R
    input wire logic [1:0] o_s_axi_rresp, // R
    input wire logic o_s_axi_rvalid, // R
    input wire logic i_s_axi_rready // R
);
    logic forced_reg;
    logic [ATTEN_W-1:0] fcode_reg;
    logic [3:0] run_cnt_reg;
    logic [4:0] lines;
    logic run_ok;
    logic wr_take;
    assign lines = {i_atten_bit_16db, i_atten_bit_8db, i_atten_bit_4db, i_atten_bit_2db,
        i_atten_bit_1db};
    assign run_ok = run_cnt_reg == 4'hf;
    assign wr_take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    // Power-up code lands a few cycles after release, so wait before judging
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            forced_reg <= 1'b0;
            fcode_reg <= 5'h00;
            run_cnt_reg <= 4'h0;
        end
        else
        begin
            if (!run_ok)
                run_cnt_reg <= run_cnt_reg + 4'h1;
            if (wr_take && i_s_axi_awaddr == REG_CTRL)
            begin
                if (i_s_axi_wstrb[CTRL_FORCE_LANE])
                    forced_reg <= i_s_axi_wdata[CTRL_FORCE_BIT];
                if (i_s_axi_wstrb[CTRL_CODE_LANE])
                    fcode_reg <= i_s_axi_wdata[CTRL_CODE_LSB +: ATTEN_W];
            end
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence seq_direct;
        (!i_mode_serial && i_latch_strobe && !forced_reg && run_ok && $stable(lines))[*8];
    endsequence
    sequence seq_frozen;
        (!i_latch_strobe && !forced_reg && run_ok)[*8];
    endsequence
    AST_DIRECT: assert property (seq_direct |-> o_atten == lines)
        else $error("code does not follow lines");
    AST_FROZEN: assert property (seq_frozen |-> $stable(o_atten))
        else $error("code moved with strobe low");
    // New forced code shows two cycles after the write is taken
    AST_FORCE: assert property (forced_reg [*4] |-> o_atten == $past(fcode_reg))
        else $error("forced code not applied");
    AST_WR_ANSWER: assert property (wr_take |=> o_s_axi_bvalid && !o_s_axi_awready)
        else $error("write not answered");
    AST_B_RELEASE: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
        else $error("write response not released");
    AST_RD_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
        o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read not answered");
    AST_R_RELEASE: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
        else $error("read data not released");
    AST_RD_SLVERR: assert property (i_s_axi_arvalid && o_s_axi_arready &&
        i_s_axi_araddr > REG_SHIFT |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // sac_top_properties

// [test/sac_host_model.sv]
// Host controller model driving the attenuator control pins
`timescale 1ns/10ps
module sac_host_model (
    input wire logic i_core_clk, // Core clock
    output logic o_mode_serial, // Interface select
    output logic o_latch_strobe, // Latch strobe
    output logic o_serial_clk, // Serial clock, idle low
    output logic o_serial_data, // Serial data
    output logic [4:0] o_lines, // Lines, 16 dB first
    output logic o_strap_a, // Strap, 16 dB
    output logic o_strap_b // Strap, 8 dB
);
    initial
    begin
        {o_mode_serial, o_latch_strobe, o_serial_clk, o_serial_data} = 4'h0;
        {o_lines, o_strap_a, o_strap_b} = 7'h00;
    end
    task automatic set_pins(input logic m, s, input logic [4:0] l, input logic a, b);
        @(posedge i_core_clk);
        o_mode_serial <= m;
        o_latch_strobe <= s;
        o_lines <= l;
        o_strap_a <= a;
        o_strap_b <= b;
    endtask
    // Fastest allowed switching rate: one commit per 40 us
    localparam real STATE_GAP_NS = 40000.0;
    real last_commit = 0.0;
    task automatic pace();
        while ($realtime - last_commit < STATE_GAP_NS)
            @(posedge i_core_clk);
        last_commit = $realtime;
    endtask
    task automatic set_lines(input logic [4:0] l);
        pace();
        @(posedge i_core_clk);
        o_lines <= l;
    endtask
    // Settle time keeps line changes clear of the strobe edge
    task automatic set_strobe(input logic s);
        @(posedge i_core_clk);
        o_latch_strobe <= s;
        repeat (4) @(posedge i_core_clk);
    endtask
    task automatic pulse_strobe();
        pace();
        @(posedge i_core_clk);
        o_latch_strobe <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        o_latch_strobe <= 1'b0;
    endtask
    task automatic send_code(input logic [4:0] code);
        logic [5:0] word;
        word = {code, 1'b0};
        @(posedge i_core_clk);
        for (int i = 5; i >= 0; i--)
        begin
            o_serial_data <= word[i];
            #50 o_serial_clk <= 1'b1;
            #62.5 o_serial_clk <= 1'b0;
            #12.5;
        end
        o_serial_data <= ~word[0];
    endtask
endmodule // sac_host_model

// [test/sac_top_tb.sv]
// Self-checking bench for the attenuator control block
`timescale 1ns/10ps
module sac_top_tb;
    import sac_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_mode_serial, i_latch_strobe, i_serial_clk, i_serial_data;
    logic i_atten_bit_16db, i_atten_bit_8db, i_atten_bit_4db, i_atten_bit_2db, i_atten_bit_1db;
    logic i_powerup_strap_a, i_powerup_strap_b, o_serial_stop_bit;
    logic [4:0] lines;
    logic [ATTEN_W-1:0] o_atten;
    logic [AXI_ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [AXI_DATA_W-1:0] i_s_axi_wdata, o_s_axi_rdata;
    logic [AXI_STRB_W-1:0] i_s_axi_wstrb;
    logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
    logic i_s_axi_arvalid, i_s_axi_rready;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic [4:0] tbl [4] = '{5'h00, 5'h08, 5'h10, 5'h1f};
    logic [4:0] codes [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f, 5'h00};
    int n_mismatch = 0;
    int num_checks = 0;
    assign {i_atten_bit_16db, i_atten_bit_8db, i_atten_bit_4db, i_atten_bit_2db,
        i_atten_bit_1db} = lines;
    always #5 i_core_clk = ~i_core_clk;
    sac_host_model u_host (.i_core_clk, .o_mode_serial(i_mode_serial),
        .o_latch_strobe(i_latch_strobe), .o_serial_clk(i_serial_clk),
        .o_serial_data(i_serial_data), .o_lines(lines), .o_strap_a(i_powerup_strap_a),
        .o_strap_b(i_powerup_strap_b));
    sac_top u_dut (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // Pins are set inside reset so they are stable when power-up samples them
    task automatic power_up(input logic m, s, input logic [4:0] l, input logic a, b);
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        u_host.set_pins(m, s, l, a, b);
        settle(16);
        i_rst_n <= 1'b1;
        settle(10);
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] e);
        @(posedge i_core_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_wstrb <= s;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
        // Only the watchdog ends a wait that never gets an answer
        do
        begin
            @(posedge i_core_clk);
            if (o_s_axi_awready)
                i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready)
                i_s_axi_wvalid <= 1'b0;
        end
        while (o_s_axi_bvalid !== 1'b1);
        i_s_axi_bready <= 1'b0;
        check({o_s_axi_bvalid, o_s_axi_bresp}, {1'b1, e});
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
        @(posedge i_core_clk);
        i_s_axi_araddr <= a;
        {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge i_core_clk);
            if (o_s_axi_arready)
                i_s_axi_arvalid <= 1'b0;
        end
        while (o_s_axi_rvalid !== 1'b1);
        i_s_axi_rready <= 1'b0;
        check({o_s_axi_rvalid, o_s_axi_rresp}, {1'b1, r});
        check(o_s_axi_rdata & m, e);
    endtask
    initial
    begin
        // Bus idle before the first reset release
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h0;
        {i_s_axi_arvalid, i_s_axi_rready} <= 2'h0;
        {i_s_axi_awaddr, i_s_axi_araddr} <= 16'h0000;
        i_s_axi_wdata <= 32'h0;
        i_s_axi_wstrb <= 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            power_up(1'b0, 1'b0, 5'h15, k[1], k[0]);
            check(o_atten, tbl[k]);
        end
        power_up(1'b0, 1'b1, 5'h0b, 1'b1, 1'b1);
        check(o_atten, 5'h0b);
        for (int i = 0; i < 7; i++)
        begin
            u_host.set_lines(codes[i]);
            settle(8);
            check(o_atten, codes[i]);
        end
        axi_read(REG_STATUS, 32'h0000_0a00, 32'h0000_0b1f, 2'h0);
        u_host.set_strobe(1'b0);
        u_host.set_lines(5'h13);
        settle(8);
        check(o_atten, 5'h00);
        u_host.pulse_strobe();
        settle(8);
        check(o_atten, 5'h13);
        u_host.send_code(5'h1c);
        u_host.set_strobe(1'b1);
        settle(8);
        check(o_atten, 5'h13);
        power_up(1'b1, 1'b0, 5'h16, 1'b0, 1'b0);
        check({o_serial_stop_bit, o_atten}, 6'h16);
        axi_read(REG_SHIFT, 32'h2c, 32'h3f, 2'h0);
        u_host.send_code(5'h09);
        settle(8);
        check(o_atten, 5'h16);
        axi_read(REG_SHIFT, 32'h12, 32'h3f, 2'h0);
        u_host.pulse_strobe();
        settle(8);
        check({o_serial_stop_bit, o_atten}, 6'h09);
        u_host.set_lines(5'h1f);
        u_host.set_strobe(1'b1);
        u_host.send_code(5'h05);
        settle(8);
        check(o_atten, 5'h05);
        u_host.set_strobe(1'b0);
        u_host.send_code(5'h1e);
        settle(8);
        check(o_atten, 5'h05);
        axi_write(REG_CTRL, 32'h0000_011a, 4'hf, 2'h0);
        settle(4);
        check(o_atten, 5'h1a);
        // Code lane alone: force stays on, code moves
        axi_write(REG_CTRL, 32'h0000_0007, 4'h1, 2'h0);
        settle(4);
        check(o_atten, 5'h07);
        axi_write(REG_STATUS, 32'hffff_ffff, 4'hf, 2'h0);
        axi_write(8'h40, 32'h0, 4'hf, 2'h2);
        axi_read(REG_CTRL, 32'h0000_0107, 32'h0000_011f, 2'h0);
        axi_read(8'h40, 32'h0, 32'hffff_ffff, 2'h2);
        // Force lane alone releases the latched code
        axi_write(REG_CTRL, 32'h0, 4'h2, 2'h0);
        settle(8);
        check(o_atten, 5'h05);
        finish_test();
    end
    initial
    begin
        // Eleven paced commits of 40 us each, plus margin
        #700000;
        n_mismatch++;
        finish_test();
    end
endmodule // sac_top_tb
bind sac_top sac_top_properties u_props (.*);
